// File: verilog/frit_pkg.sv
// Purpose: Shared constants and types of the free-running and interval timer.
// Assumes: 100 MHz ref_clk, 4 MHz counting timebase, APB with one word per register.
// Notes: Byte address of a register is four times its index.
package frit_pkg;

	// Clock and timebase
	localparam int REF_CLK_HZ = 100_000_000;
	localparam int TIMEBASE_HZ = 4_000_000;
	localparam int TB_DIV = REF_CLK_HZ / TIMEBASE_HZ;

	// Periodic tick and counter wrap
	localparam int TICK_PERIOD_US = 1024;
	localparam int TICK_STEPS = TICK_PERIOD_US * (TIMEBASE_HZ / 1_000_000);
	localparam int WRAP_PERIOD_US = 16_384;
	localparam int WRAP_STEPS = WRAP_PERIOD_US * (TIMEBASE_HZ / 1_000_000);

	// Widths
	localparam int FREE_W = 16;
	localparam int INT_W = 12;
	localparam int ADDR_W = 12;
	localparam int DATA_W = 32;

	// Register indices
	localparam logic [7:0] IDX_FREE_LOW = 8'h20;
	localparam logic [7:0] IDX_FREE_HIGH = 8'h21;
	localparam logic [7:0] IDX_INT_LOW = 8'h26;
	localparam logic [7:0] IDX_INT_HIGH = 8'h27;
	localparam logic [7:0] IDX_RELOAD_LOW = 8'h28;
	localparam logic [7:0] IDX_RELOAD_HIGH = 8'h29;
	localparam logic [7:0] IDX_IRQ_CLEAR = 8'h2a;

	// Reset values
	localparam logic [15:0] FREE_RESET = 16'h0000;
	localparam logic [11:0] INT_RESET = 12'h000;
	localparam logic [7:0] BYTE_RESET = 8'h00;

	// Fields of the interrupt clear register
	localparam int IRQ_TICK_BIT = 0;
	localparam int IRQ_INTERVAL_BIT = 1;
	localparam int IRQ_WRAP_BIT = 2;

	// Fixed vectors and priorities
	localparam logic [15:0] VEC_TICK = 16'h0034;
	localparam logic [15:0] VEC_INTERVAL = 16'h0038;
	localparam logic [15:0] VEC_WRAP = 16'h0044;
	localparam logic [4:0] PRI_TICK = 5'h0d;
	localparam logic [4:0] PRI_INTERVAL = 5'h0e;
	localparam logic [4:0] PRI_WRAP = 5'h11;

	typedef struct packed {
		logic wrap;
		logic interval;
		logic tick;
	} frit_irq_t;

endpackage

// File: verilog/frit_timebase.sv
// Purpose: Counting timebase of the timer, delivered as a one-cycle step.
// Assumes: DIV ref_clk cycles per timebase period.
// Notes: The timebase toggle reaches the register side through a two-flop crossing.
module frit_timebase #(
	parameter int DIV = 25
) (
	input wire logic ref_clk,
	input wire logic rstSyncN,
	output logic step
);

	localparam int CW = $clog2(DIV);
	localparam logic [CW-1:0] LAST = CW'(DIV - 1);

	logic [CW-1:0] divCount;
	logic tbToggle;
	logic syncA;
	logic syncB;
	logic syncC;
	logic divWrap;

	generate
		if (DIV < 2) begin : g_bad_div
			$error("frit_timebase: DIV must be at least 2");
		end
	endgenerate

	assign divWrap = (divCount == LAST);

	// Timebase divider, toggles once per period
	always_ff @(posedge ref_clk or negedge rstSyncN) begin
		if (!rstSyncN) begin
			divCount <= '0;
			tbToggle <= 1'b0;
		end else begin
			divCount <= divWrap ? '0 : divCount + CW'(1);
			tbToggle <= divWrap ? ~tbToggle : tbToggle;
		end
	end

	always_ff @(posedge ref_clk or negedge rstSyncN) begin
		if (!rstSyncN) begin
			syncA <= 1'b0;
			syncB <= 1'b0;
			syncC <= 1'b0;
			step <= 1'b0;
		end else begin
			syncA <= tbToggle;
			syncB <= syncA;
			syncC <= syncB;
			step <= syncB ^ syncC;
		end
	end

endmodule

// File: verilog/frit_timer.sv
// Purpose: Free-running 16-bit counter and 12-bit interval timer behind APB.
// Assumes: APB master keeps to low byte first, high byte second.
// Notes: No wait state on any access; registers sit in the low byte.
//
// The APB register port was chosen for this implementation.
module frit_timer
	import frit_pkg::*;
#(
	parameter int DIV = TB_DIV
) (
	input wire logic ref_clk,
	input wire logic rstn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [DATA_W-1:0] pwdata,
	output logic [DATA_W-1:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic tickIrq,
	output logic intervalIrq,
	output logic wrapIrq,
	output logic irqValid,
	output logic [15:0] irqVector,
	output logic [4:0] irqPriority,
	input wire logic irqAck
);

	logic rstMetaN;
	logic rstSyncN;

	logic tbStep;

	logic [FREE_W-1:0] freeCount;
	logic [FREE_W-1:0] next_freeCount;
	logic [7:0] freeLowHold;
	logic [7:0] freeHighHold;

	logic [INT_W-1:0] intCount;
	logic [INT_W-1:0] next_intCount;
	logic [3:0] intHighHold;
	logic [7:0] reloadLowPend;
	logic [INT_W-1:0] reload;

	frit_irq_t posted;
	frit_irq_t next_posted;
	frit_irq_t events;
	frit_irq_t swClear;
	frit_irq_t ackClear;
	frit_irq_t present;
	frit_irq_t next_present;

	// Refuse settings the logic cannot serve
	generate
		if (DIV < 2) begin : g_bad_div
			$error("frit_timer: DIV must be at least 2");
		end
		if (ADDR_W < 11) begin : g_bad_addr
			$error("frit_timer: ADDR_W too narrow for the register map");
		end
		if (FREE_W != 16 || INT_W != 12) begin : g_bad_width
			$error("frit_timer: counter widths are fixed by the byte map");
		end
	endgenerate

	// Bus decode
	wire setupPh = psel & ~penable;
	wire accessDone = psel & penable & pready;
	wire rdSetup = setupPh & ~pwrite;
	wire [7:0] addrIdx = paddr[9:2];
	wire addrAligned = (paddr[1:0] == 2'b00) && (paddr[ADDR_W-1:10] == '0);
	wire hitFreeLow = addrAligned && (addrIdx == IDX_FREE_LOW);
	wire hitFreeHigh = addrAligned && (addrIdx == IDX_FREE_HIGH);
	wire hitIntLow = addrAligned && (addrIdx == IDX_INT_LOW);
	wire hitIntHigh = addrAligned && (addrIdx == IDX_INT_HIGH);
	wire hitRelLow = addrAligned && (addrIdx == IDX_RELOAD_LOW);
	wire hitRelHigh = addrAligned && (addrIdx == IDX_RELOAD_HIGH);
	wire hitClr = addrAligned && (addrIdx == IDX_IRQ_CLEAR);
	wire mapped = hitFreeLow | hitFreeHigh | hitIntLow | hitIntHigh | hitRelLow
		| hitRelHigh | hitClr;
	wire writeRo = pwrite & (hitIntLow | hitIntHigh);
	wire next_err = setupPh & (~mapped | writeRo);
	wire wrOk = accessDone & pwrite & ~pslverr;
	wire wrFreeLow = wrOk & hitFreeLow;
	wire wrFreeHigh = wrOk & hitFreeHigh;
	wire wrRelLow = wrOk & hitRelLow;
	wire wrRelHigh = wrOk & hitRelHigh;
	wire wrClr = wrOk & hitClr;

	// Read data selection
	wire [2:0] postedBits = {posted.wrap, posted.interval, posted.tick};
	wire [7:0] rdByte =
		hitFreeLow ? freeCount[7:0] :
		hitFreeHigh ? freeHighHold :
		hitIntLow ? intCount[7:0] :
		hitIntHigh ? {4'h0, intHighHold} :
		hitRelLow ? reloadLowPend :
		hitRelHigh ? {4'h0, reload[11:8]} :
		hitClr ? {5'h00, postedBits} :
		BYTE_RESET;
	// Data and read side effects are taken at the setup edge
	wire [DATA_W-1:0] next_prdata = rdSetup ? {24'h000000, rdByte} : prdata;

	// Reset release through two flops
	// Asserts at once, releases on an edge so no flop sees a runt
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			rstMetaN <= 1'b0;
			rstSyncN <= 1'b0;
		end else begin
			rstMetaN <= 1'b1;
			rstSyncN <= rstMetaN;
		end
	end

	frit_timebase #(
		.DIV(DIV)
	) u_timebase (
		.ref_clk(ref_clk),
		.rstSyncN(rstSyncN),
		.step(tbStep)
	);

	// load all bits on high write
	assign next_freeCount = wrFreeHigh ? {pwdata[7:0], freeLowHold} :
		tbStep ? freeCount + 16'h0001 : freeCount;

	assign next_intCount = !tbStep ? intCount :
		(intCount == '0) ? reload : intCount - 12'h001;

	// A high write in the same cycle wins, so no tick or wrap event fires
	// tick every 4096 counts
	assign events.tick = tbStep && !wrFreeHigh && (freeCount[11:0] == 12'hfff);
	assign events.wrap = tbStep && !wrFreeHigh && (freeCount == 16'hffff);
	assign events.interval = tbStep && (intCount == '0);

	assign swClear.tick = wrClr & ~pwdata[IRQ_TICK_BIT];
	assign swClear.interval = wrClr & ~pwdata[IRQ_INTERVAL_BIT];
	assign swClear.wrap = wrClr & ~pwdata[IRQ_WRAP_BIT];

	assign ackClear = irqAck ? present : '0;

	// posted until cleared, new event wins
	assign next_posted = (posted & ~swClear & ~ackClear) | events;

	assign next_present.tick = next_posted.tick;
	assign next_present.interval = next_posted.interval & ~next_posted.tick;
	assign next_present.wrap = next_posted.wrap & ~next_posted.tick & ~next_posted.interval;

	wire [15:0] next_vector = next_present.tick ? VEC_TICK :
		next_present.interval ? VEC_INTERVAL :
		next_present.wrap ? VEC_WRAP : 16'h0000;
	wire [4:0] next_priority = next_present.tick ? PRI_TICK :
		next_present.interval ? PRI_INTERVAL :
		next_present.wrap ? PRI_WRAP : 5'h00;

	// APB slave, no wait state
	always_ff @(posedge ref_clk or negedge rstSyncN) begin
		if (!rstSyncN) begin
			pready <= 1'b0;
		end else begin
			pready <= setupPh;
		end
	end

	// Error flag stands with pready only
	always_ff @(posedge ref_clk or negedge rstSyncN) begin
		if (!rstSyncN) begin
			pslverr <= 1'b0;
		end else begin
			pslverr <= next_err;
		end
	end

	// Read data stands until the next read setup
	always_ff @(posedge ref_clk or negedge rstSyncN) begin
		if (!rstSyncN) begin
			prdata <= '0;
		end else begin
			prdata <= next_prdata;
		end
	end

	// Free-running counter
	always_ff @(posedge ref_clk or negedge rstSyncN) begin
		if (!rstSyncN) begin
			freeCount <= FREE_RESET;
		end else begin
			freeCount <= next_freeCount;
		end
	end

	always_ff @(posedge ref_clk or negedge rstSyncN) begin
		if (!rstSyncN) begin
			freeLowHold <= BYTE_RESET;
		end else if (wrFreeLow) begin
			freeLowHold <= pwdata[7:0];
		end
	end

	// Sampled at setup, so the high read returns this instant
	// capture high byte on low read
	always_ff @(posedge ref_clk or negedge rstSyncN) begin
		if (!rstSyncN) begin
			freeHighHold <= BYTE_RESET;
		end else if (rdSetup && hitFreeLow) begin
			freeHighHold <= freeCount[15:8];
		end
	end

	// Interval counter
	always_ff @(posedge ref_clk or negedge rstSyncN) begin
		if (!rstSyncN) begin
			intCount <= INT_RESET;
		end else begin
			intCount <= next_intCount;
		end
	end

	// nibble as of the last low read
	always_ff @(posedge ref_clk or negedge rstSyncN) begin
		if (!rstSyncN) begin
			intHighHold <= 4'h0;
		end else if (rdSetup && hitIntLow) begin
			intHighHold <= intCount[11:8];
		end
	end

	// Reload low byte waits for the nibble
	always_ff @(posedge ref_clk or negedge rstSyncN) begin
		if (!rstSyncN) begin
			reloadLowPend <= BYTE_RESET;
		end else if (wrRelLow) begin
			reloadLowPend <= pwdata[7:0];
		end
	end

	// Reload commits on nibble write
	always_ff @(posedge ref_clk or negedge rstSyncN) begin
		if (!rstSyncN) begin
			reload <= INT_RESET;
		end else if (wrRelHigh) begin
			reload <= {pwdata[3:0], reloadLowPend};
		end
	end

	always_ff @(posedge ref_clk or negedge rstSyncN) begin
		if (!rstSyncN) begin
			posted <= '0;
		end else begin
			posted <= next_posted;
		end
	end

	always_ff @(posedge ref_clk or negedge rstSyncN) begin
		if (!rstSyncN) begin
			present <= '0;
		end else begin
			present <= next_present;
		end
	end

	// Any request posted
	always_ff @(posedge ref_clk or negedge rstSyncN) begin
		if (!rstSyncN) begin
			irqValid <= 1'b0;
		end else begin
			irqValid <= |next_posted;
		end
	end

	always_ff @(posedge ref_clk or negedge rstSyncN) begin
		if (!rstSyncN) begin
			irqVector <= 16'h0000;
		end else begin
			irqVector <= next_vector;
		end
	end

	always_ff @(posedge ref_clk or negedge rstSyncN) begin
		if (!rstSyncN) begin
			irqPriority <= 5'h00;
		end else begin
			irqPriority <= next_priority;
		end
	end

	always_ff @(posedge ref_clk or negedge rstSyncN) begin
		if (!rstSyncN) begin
			tickIrq <= 1'b0;
		end else begin
			tickIrq <= next_posted.tick;
		end
	end

	always_ff @(posedge ref_clk or negedge rstSyncN) begin
		if (!rstSyncN) begin
			intervalIrq <= 1'b0;
		end else begin
			intervalIrq <= next_posted.interval;
		end
	end

	always_ff @(posedge ref_clk or negedge rstSyncN) begin
		if (!rstSyncN) begin
			wrapIrq <= 1'b0;
		end else begin
			wrapIrq <= next_posted.wrap;
		end
	end

endmodule

// File: testbench/frit_timer_assertions.sv
// Purpose: Port-level checks of the timer.
// Assumes: One clock, rstn low resets.
// Notes: Bound to every timer instance.
module frit_timer_assertions
	import frit_pkg::*;
#(
	parameter int DIV = 25
) (
	input wire logic ref_clk,
	input wire logic rstn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [DATA_W-1:0] pwdata,
	input wire logic [DATA_W-1:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic tickIrq,
	input wire logic intervalIrq,
	input wire logic wrapIrq,
	input wire logic irqValid,
	input wire logic [15:0] irqVector,
	input wire logic [4:0] irqPriority,
	input wire logic irqAck
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rstn);
	sequence s_setup;
		psel && !penable;
	endsequence
	sequence s_done;
		pready ##1 !pready;
	endsequence
	a_ready_after_setup: assert property (s_setup |=> s_done)
		else $error("no single ready after setup");
	a_err_refused: assert property (pready && (paddr[1:0] != 0 || paddr[11:10] != 0) |-> pslverr)
		else $error("refused address not flagged");
	a_high_nibble: assert property (
		pready && !pwrite && paddr == 12'h09c |-> prdata[31:4] == 0)
		else $error("interval high upper bits set");
	a_vec_tick: assert property (
		tickIrq |-> irqVector == 16'h0034 && irqPriority == 5'h0d)
		else $error("tick vector wrong");
	a_vec_interval: assert property (
		!tickIrq && intervalIrq |-> irqVector == 16'h0038 && irqPriority == 5'h0e)
		else $error("interval vector wrong");
	a_vec_wrap: assert property (
		!tickIrq && !intervalIrq && wrapIrq |-> irqVector == 16'h0044 && irqPriority == 5'h11)
		else $error("wrap vector wrong");
	a_valid_any: assert property (irqValid == (tickIrq || intervalIrq || wrapIrq))
		else $error("valid differs from posted bits");
	a_tick_held: assert property (tickIrq && !irqAck && !(psel && pwrite) |=> tickIrq)
		else $error("tick request dropped");
	a_wrap_held: assert property (wrapIrq && !irqAck && !(psel && pwrite) |=> wrapIrq)
		else $error("wrap request dropped");
endmodule

bind frit_timer frit_timer_assertions #(.DIV(DIV)) uChk (.ref_clk(ref_clk), .rstn(rstn),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
	.prdata(prdata), .pready(pready), .pslverr(pslverr), .tickIrq(tickIrq),
	.intervalIrq(intervalIrq), .wrapIrq(wrapIrq), .irqValid(irqValid),
	.irqVector(irqVector), .irqPriority(irqPriority), .irqAck(irqAck));

// File: testbench/tb_top.sv
// Purpose: Self-checking bench of the timer over APB.
// Assumes: DIV of 2, no wait state on any access.
// Notes: Counter is preloaded near its top to reach a wrap quickly.
module tb_top
	import frit_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic ref_clk = 0, rstn = 0, psel = 0, penable = 0, pwrite = 0, irqAck = 0;
	logic [11:0] paddr = 0;
	logic [31:0] pwdata = 0, prdata, rv;
	logic pready, pslverr, er, tickIrq, intervalIrq, wrapIrq, irqValid;
	logic [15:0] irqVector;
	logic [4:0] irqPriority;
	int miscompares = 0, checks_done = 0, cyc = 0, n;
	realtime t1;
	frit_timer #(.DIV(2)) uut (.ref_clk(ref_clk), .rstn(rstn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .tickIrq(tickIrq), .intervalIrq(intervalIrq), .wrapIrq(wrapIrq),
		.irqValid(irqValid), .irqVector(irqVector), .irqPriority(irqPriority), .irqAck(irqAck));
	initial begin
		forever #5 ref_clk = ~ref_clk;
	end
	task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] x);
		checks_done++;
		if (s !== x) begin
			miscompares++;
			$display("mismatch %s expected %h seen %h", nm, x, s);
		end
	endtask
	task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
		int k;
		@(posedge ref_clk);
		psel <= 1;
		penable <= 0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge ref_clk);
		penable <= 1;
		k = 0;
		do begin
			@(posedge ref_clk);
			k++;
		end while (pready !== 1'b1 && k < 50);
		chk("pready", pready, 1);
		rv = prdata;
		er = pslverr;
		psel <= 0;
		penable <= 0;
	endtask
	task automatic waitrise(input int lim);
		// Skip the edge whose clear is still settling
		@(posedge ref_clk);
		n = 0;
		while (intervalIrq !== 1'b1 && n < lim) begin
			@(posedge ref_clk);
			n++;
		end
	endtask
	task automatic t_regs();
		bus(0, 12'h0a0, 0);
		chk("reload_low", rv, 0);
		bus(1, 12'h098, 8'h55);
		chk("ro_write_err", er, 1);
		bus(0, 12'h400, 0);
		chk("unmapped_err", er, 1);
		chk("unmapped_data", rv, 0);
		$display("test regs done");
	endtask
	task automatic t_interval();
		bus(1, 12'h0a0, 8'h05);
		bus(1, 12'h0a4, 8'h00);
		bus(1, 12'h0a8, 3'b101);
		waitrise(100);
		t1 = $realtime;
		bus(1, 12'h0a8, 3'b101);
		waitrise(100);
		chk("interval_period", ($realtime - t1) / 10, 12);
		bus(1, 12'h0a0, 8'hff);
		bus(1, 12'h0a4, 8'h03);
		bus(0, 12'h0a4, 0);
		chk("reload_high", rv, 8'h03);
		bus(1, 12'h0a8, 3'b101);
		bus(0, 12'h098, 0);
		repeat (600) @(posedge ref_clk);
		bus(0, 12'h09c, 0);
		chk("interval_nibble", rv, 8'h03);
		bus(1, 12'h0a0, 8'hff);
		bus(1, 12'h0a4, 8'h0f);
		bus(1, 12'h0a8, 3'b101);
		waitrise(2000);
		chk("interval_restart", intervalIrq, 1);
		bus(1, 12'h0a8, 0);
		$display("test interval done");
	endtask
	task automatic t_counter();
		bus(1, 12'h080, 8'hf0);
		bus(1, 12'h084, 8'hff);
		bus(0, 12'h080, 0);
		chk("count_low_range", rv[7:0] >= 8'hf0, 1);
		bus(0, 12'h084, 0);
		chk("count_high", rv, 8'hff);
		n = 0;
		while (wrapIrq !== 1'b1 && n < 100) begin
			@(posedge ref_clk);
			n++;
		end
		chk("wrap_posted", wrapIrq, 1);
		chk("tick_posted", tickIrq, 1);
		chk("tick_vector", irqVector, 16'h0034);
		bus(0, 12'h0a8, 0);
		chk("clear_read", rv, 3'b101);
		irqAck <= 1;
		@(posedge ref_clk);
		irqAck <= 0;
		@(posedge ref_clk);
		chk("tick_acked", tickIrq, 0);
		chk("wrap_vector", irqVector, 16'h0044);
		chk("wrap_prio", irqPriority, 5'h11);
		bus(1, 12'h0a8, 3'b011);
		@(posedge ref_clk);
		chk("wrap_cleared", irqValid, 0);
		bus(0, 12'h080, 0);
		repeat (600) @(posedge ref_clk);
		bus(0, 12'h084, 0);
		chk("held_high", rv, 0);
		$display("test counter done");
	endtask
	task automatic results();
		$display("checks %0d mismatches %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	always @(posedge ref_clk) begin
		cyc++;
		if (cyc == 30000) begin
			miscompares++;
			results();
		end
	end
	initial begin
		repeat (6) @(posedge ref_clk);
		rstn <= 1;
		repeat (3) @(posedge ref_clk);
		t_regs();
		t_interval();
		t_counter();
		results();
	end
endmodule
